// ### cmdmb_pkg.sv
// Purpose: Shared constants for the command mailbox handshake.
// Assumes: One clock, entries are three 32-bit words.
// Notes: Entry word 0 control, word 1 block pointer, word 2 block head.
//
// Summary of operation
// - Priority and queue slots share 12-byte layout
// - Host sets semaphore, leaves slot until cleared
// - Board clears semaphore when slot free again
// - Priority slot served before circular queue
// - Work queue zero, depth one, runs first
// - Reset and flush accepted into full queue zero
// - Narrow 14, wide 255 general work queues; queue number never checked, q_wq_ok unused
// - Priority command copied, executed, then response written
// - Completion sets valid bit 0, optional interrupt
// - Host reads response then clears valid flag
// - Queue circular, host tracks slot, order kept
// - Semaphore set notifies board; board also polls
// - Board copies slot, then clears its semaphore
// - Queue commands run in order unless priority
// - Descriptor starts at parameter block word 0x10
// - Group code decodes descriptor length
// - Known groups ignore slot length field
// - Groups 6, 7: length minus 0x10 words
// - Completion raises interrupt only if entry IRQ enable set
// - Acknowledge cycle returns cause-chosen vector
// - Request line drops when acknowledge completes
// - Next interrupt waits for valid flag clear
package cmdmb_pkg;
  localparam int ENTRY_W = 96;          // 12 bytes
  localparam int QDEPTH = 4;            // Circular queue slots
  localparam int QIDX_W = 2;
  localparam int GQ_DEPTH = 4;          // General work queue store
  localparam int GQ_W = 2;
  localparam logic [7:0] WQ_MAX_NARROW = 8'h0e;
  localparam logic [7:0] WQ_MAX_WIDE = 8'hff;
  localparam logic WIDE = 1'b0;
  // Entry word 0 fields
  localparam int F_GO = 0;
  localparam int F_HIPRI = 1;
  localparam int F_IRQ_EN = 2;
  localparam int F_WQ_LSB = 8;
  localparam int F_LEN_LSB = 16;
  // Entry word 2 fields (head of parameter block)
  localparam int F_CDB0_LSB = 64;
  localparam int F_CODE_LSB = 72;
  localparam int F_EVEC_LSB = 80;
  localparam int F_NVEC_LSB = 88;
  localparam logic [7:0] CODE_BUS_RESET = 8'h22;
  localparam logic [7:0] CODE_FLUSH = 8'h49;
  localparam logic [15:0] PB_OVERHEAD = 16'h0010;  // Words before CDB
  // Response status word bits
  localparam int S_VALID = 0;
  localparam int S_ERROR = 1;
  localparam int S_BADLEN = 2;
  localparam int S_WQ_LSB = 8;
  // Polling interval of the queue pointer slot
  localparam int POLL_NS = 160;
  localparam int CLK_NS = 10;
  localparam logic [4:0] POLL_CYC = 5'((POLL_NS + CLK_NS - 1) / CLK_NS);
  // Host register offsets
  localparam logic [7:0] A_ENTRY0 = 8'h00;
  localparam logic [7:0] A_ENTRY1 = 8'h04;
  localparam logic [7:0] A_ENTRY2 = 8'h08;
  localparam logic [7:0] A_SUBMIT = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_RSTAT = 8'h14;
  localparam logic [7:0] A_RESP0 = 8'h18;
  localparam logic [7:0] A_RESP1 = 8'h1c;
  localparam logic [7:0] A_RESP2 = 8'h20;
  localparam logic [7:0] A_ACK = 8'h24;
  localparam logic [7:0] A_VECTOR = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### command_mailbox_if.sv
// Purpose: Shared-memory view between host and board.
// Assumes: Both ends on aclk; semaphore bits are kept by the board.
// Notes: Set and clear strobes are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
interface command_mailbox_if
  import cmdmb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn
);
  logic pri_set;
  logic [ENTRY_W-1:0] pri_entry;
  logic pri_busy;
  logic q_set;
  logic [QIDX_W-1:0] q_idx;
  logic [ENTRY_W-1:0] q_entry;
  logic [QDEPTH-1:0] q_busy;
  logic resp_clr;
  logic [31:0] resp_status;
  logic [ENTRY_W-1:0] resp_entry;
  logic irq_req;
  logic iack;
  logic [7:0] iack_vector;
  modport dev (
    input pri_set, pri_entry, q_set, q_idx, q_entry, resp_clr, iack,
    output pri_busy, q_busy, resp_status, resp_entry, irq_req, iack_vector
  );
  modport host (
    output pri_set, pri_entry, q_set, q_idx, q_entry, resp_clr, iack,
    input pri_busy, q_busy, resp_status, resp_entry, irq_req, iack_vector
  );
endinterface
`default_nettype wire

// ### command_mailbox_device.sv
// Purpose: Board end: slots, work queues, response block, interrupt.
// Assumes: The executing engine answers cmd_valid with cmd_done.
// Notes: Queue zero has a second place used only for recovery commands.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module command_mailbox_device
  import cmdmb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Mailbox
  command_mailbox_if.dev mb,
  // Execution engine
  output logic cmd_valid,
  output logic [ENTRY_W-1:0] cmd_entry,
  output logic [7:0] cmd_cdb_len,
  input wire logic cmd_done,
  input wire logic cmd_error
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_POST = 3'b100
  } state_e;

  state_e state_reg, state_next;
  logic pri_busy_reg;
  logic [ENTRY_W-1:0] pri_entry_reg;
  logic [ENTRY_W-1:0] q_mem [QDEPTH];
  logic [QDEPTH-1:0] q_busy_reg;
  logic [QIDX_W-1:0] qptr_reg;
  logic note_reg;
  logic [4:0] poll_reg;
  logic wq0_full_reg, wq0r_full_reg, hp_full_reg;
  logic [ENTRY_W-1:0] wq0_reg, wq0r_reg, hp_reg;
  logic [ENTRY_W-1:0] gq_mem [GQ_DEPTH];
  logic [GQ_W-1:0] gq_rd_reg, gq_wr_reg;
  logic [GQ_W:0] gq_cnt_reg;
  logic [ENTRY_W-1:0] cur_reg;
  logic [7:0] len_reg;
  logic bad_reg, err_reg;
  logic [31:0] rstat_reg;
  logic [ENTRY_W-1:0] rentry_reg;
  logic irq_reg;
  logic [7:0] vec_reg;
  logic [ENTRY_W-1:0] qcur;
  logic pri_rec, take_pri, take_q, q_hp, q_wq_ok;
  logic start, s_rec, s_wq0, s_hp, s_gq;
  logic [7:0] wq_max;

  // Descriptor length in bytes; zero marks a reserved group
  function automatic logic [7:0] cdb_len(input logic [ENTRY_W-1:0] e);
    logic [2:0] grp;
    logic [15:0] words;
    // top three bits of descriptor byte 0
    grp = e[F_CDB0_LSB+7 -: 3];
    words = e[F_LEN_LSB +: 16] - PB_OVERHEAD;
    case (grp)
      // length by group; slot length unused
      3'h0: cdb_len = 8'h06;
      3'h1, 3'h2: cdb_len = 8'h0a;
      3'h5: cdb_len = 8'h0c;
      // user groups use slot length less overhead
      3'h6, 3'h7: cdb_len = {words[6:0], 1'b0};
      default: cdb_len = 8'h00;
    endcase
  endfunction

  // general work queue numbers by variant
  assign wq_max = WIDE ? WQ_MAX_WIDE : WQ_MAX_NARROW;

  // Slot selection
  assign qcur = q_mem[qptr_reg];
  assign q_hp = qcur[F_HIPRI];
  assign q_wq_ok = qcur[F_WQ_LSB +: 8] <= wq_max;
  assign pri_rec = pri_entry_reg[F_CODE_LSB +: 8] == CODE_BUS_RESET ||
                   pri_entry_reg[F_CODE_LSB +: 8] == CODE_FLUSH;
  // recovery command enters even a full queue zero
  assign take_pri = pri_busy_reg &&
                    (!wq0_full_reg || (pri_rec && !wq0r_full_reg));
  // priority slot blocks queue intake this cycle
  // take on notification or poll of pointer slot
  assign take_q = !take_pri && q_busy_reg[qptr_reg] &&
                  (note_reg || poll_reg == 5'h00) &&
                  (q_hp ? !hp_full_reg : gq_cnt_reg != GQ_DEPTH);

  // queue zero first, then high priority, then in order
  assign start = state_reg == ST_IDLE;
  assign s_rec = start && wq0r_full_reg;
  assign s_wq0 = start && !wq0r_full_reg && wq0_full_reg;
  assign s_hp = start && !wq0r_full_reg && !wq0_full_reg && hp_full_reg;
  assign s_gq = start && !wq0r_full_reg && !wq0_full_reg &&
                !hp_full_reg && gq_cnt_reg != 0;

  // Priority slot semaphore
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_busy_reg <= 1'b0;
      pri_entry_reg <= '0;
    end else if (mb.pri_set) begin
      pri_busy_reg <= 1'b1;
      pri_entry_reg <= mb.pri_entry;
    end else if (take_pri) begin
      pri_busy_reg <= 1'b0;
    end
  end

  // queue slots hold the same entry layout
  always_ff @(posedge aclk) begin
    if (mb.q_set) begin
      q_mem[mb.q_idx] <= mb.q_entry;
    end
  end

  // Queue semaphores, set wins over clear
  for (genvar i = 0; i < QDEPTH; i++) begin : g_qbusy
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        q_busy_reg[i] <= 1'b0;
      end else if (mb.q_set && mb.q_idx == QIDX_W'(i)) begin
        q_busy_reg[i] <= 1'b1;
      end else if (take_q && qptr_reg == QIDX_W'(i)) begin
        q_busy_reg[i] <= 1'b0;
      end
    end
  end

  // pointer walks the ring in submission order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qptr_reg <= '0;
    end else if (take_q) begin
      qptr_reg <= qptr_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      note_reg <= 1'b0;
      poll_reg <= POLL_CYC;
    end else begin
      if (mb.q_set) begin
        note_reg <= 1'b1;
      end else if (take_q) begin
        note_reg <= 1'b0;
      end
      poll_reg <= (poll_reg == 5'h00) ? POLL_CYC : poll_reg - 1'b1;
    end
  end

  // priority command copied into queue zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wq0_full_reg <= 1'b0;
      wq0r_full_reg <= 1'b0;
      wq0_reg <= '0;
      wq0r_reg <= '0;
    end else begin
      if (take_pri && !wq0_full_reg) begin
        wq0_full_reg <= 1'b1;
        wq0_reg <= pri_entry_reg;
      end else if (s_wq0) begin
        wq0_full_reg <= 1'b0;
      end
      if (take_pri && wq0_full_reg) begin
        wq0r_full_reg <= 1'b1;
        wq0r_reg <= pri_entry_reg;
      end else if (s_rec) begin
        wq0r_full_reg <= 1'b0;
      end
    end
  end

  // high priority place jumps the ordered store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hp_full_reg <= 1'b0;
      hp_reg <= '0;
    end else if (take_q && q_hp) begin
      hp_full_reg <= 1'b1;
      hp_reg <= qcur;
    end else if (s_hp) begin
      hp_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (take_q && !q_hp) begin
      gq_mem[gq_wr_reg] <= qcur;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gq_wr_reg <= '0;
      gq_rd_reg <= '0;
      gq_cnt_reg <= '0;
    end else begin
      if (take_q && !q_hp) begin
        gq_wr_reg <= gq_wr_reg + 1'b1;
      end
      if (s_gq) begin
        gq_rd_reg <= gq_rd_reg + 1'b1;
      end
      gq_cnt_reg <= gq_cnt_reg + {2'b00, take_q && !q_hp} -
                    {2'b00, s_gq};
    end
  end

  // Execution sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (s_rec || s_wq0 || s_hp || s_gq) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cmd_done) begin
          state_next = ST_POST;
        end
      end
      // wait until host frees the response block
      ST_POST: begin
        if (!rstat_reg[S_VALID]) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Current command and its decoded length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_reg <= '0;
      len_reg <= '0;
      bad_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && state_next == ST_RUN) begin
      cur_reg <= s_rec ? wq0r_reg : s_wq0 ? wq0_reg :
                 s_hp ? hp_reg : gq_mem[gq_rd_reg];
      len_reg <= cdb_len(s_rec ? wq0r_reg : s_wq0 ? wq0_reg :
                         s_hp ? hp_reg : gq_mem[gq_rd_reg]);
      bad_reg <= cdb_len(s_rec ? wq0r_reg : s_wq0 ? wq0_reg :
                         s_hp ? hp_reg : gq_mem[gq_rd_reg]) == 8'h00;
      err_reg <= 1'b0;
    end else if (state_reg == ST_RUN && cmd_done) begin
      err_reg <= cmd_error;
    end
  end

  // Response block; valid set wins over host clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstat_reg <= '0;
      rentry_reg <= '0;
    end else if (state_reg == ST_POST && !rstat_reg[S_VALID]) begin
      rentry_reg <= cur_reg;
      rstat_reg <= '0;
      rstat_reg[S_VALID] <= 1'b1;
      rstat_reg[S_ERROR] <= err_reg;
      rstat_reg[S_BADLEN] <= bad_reg;
      rstat_reg[S_WQ_LSB +: 8] <= cur_reg[F_WQ_LSB +: 8];
    end else if (mb.resp_clr) begin
      rstat_reg[S_VALID] <= 1'b0;
    end
  end

  // interrupt at each completion when enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
      vec_reg <= '0;
    end else if (state_reg == ST_POST && !rstat_reg[S_VALID] &&
                 cur_reg[F_IRQ_EN]) begin
      irq_reg <= 1'b1;
      vec_reg <= (err_reg || bad_reg) ? cur_reg[F_EVEC_LSB +: 8] :
                 cur_reg[F_NVEC_LSB +: 8];
    end else if (mb.iack) begin
      irq_reg <= 1'b0;
    end
  end

  // Outputs
  assign cmd_valid = state_reg == ST_RUN;
  assign cmd_entry = cur_reg;
  assign cmd_cdb_len = len_reg;
  assign mb.pri_busy = pri_busy_reg;
  assign mb.q_busy = q_busy_reg;
  assign mb.resp_status = rstat_reg;
  assign mb.resp_entry = rentry_reg;
  assign mb.irq_req = irq_reg;
  assign mb.iack_vector = vec_reg;
endmodule
`default_nettype wire

// ### command_mailbox_host.sv
// Purpose: Host end: AXI4-Lite registers drive slot submissions.
// Assumes: Software fills entry words, then writes the submit register.
// Notes: A submit to a slot still owned by the board is dropped.
`timescale 1ns/100ps
`default_nettype none
module command_mailbox_host
  import cmdmb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mailbox
  command_mailbox_if.host mb
);
  logic aw_got_reg, w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] ent_reg [3];
  logic [QIDX_W-1:0] next_reg;
  logic pri_set_reg, q_set_reg, clr_reg, iack_reg, iack_done_reg;
  logic [7:0] vector_reg;
  logic do_wr, sub_ok;
  logic [31:0] rd_val;
  logic rd_ok;

  assign do_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
  // submit only to a slot the board does not own
  assign sub_ok = wdata_reg[0] ? !mb.pri_busy : !mb.q_busy[next_reg];

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_wr) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready = !w_got_reg;

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg <= A_SUBMIT || awaddr_reg == A_ACK) ?
                     RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ent_reg[i] <= '0;
      end else if (do_wr && awaddr_reg == 8'(4 * i)) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            ent_reg[i][8*b +: 8] <= wdata_reg[8*b +: 8];
          end
        end
      end
    end
  end

  // Submission strobes and ring pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_set_reg <= 1'b0;
      q_set_reg <= 1'b0;
      next_reg <= '0;
    end else begin
      pri_set_reg <= do_wr && awaddr_reg == A_SUBMIT && sub_ok &&
                     wdata_reg[0];
      q_set_reg <= do_wr && awaddr_reg == A_SUBMIT && sub_ok &&
                   !wdata_reg[0];
      // host tracks its next free slot
      if (do_wr && awaddr_reg == A_SUBMIT && sub_ok && !wdata_reg[0]) begin
        next_reg <= next_reg + 1'b1;
      end
    end
  end

  assign mb.pri_set = pri_set_reg;
  assign mb.q_set = q_set_reg;
  assign mb.q_idx = next_reg - 1'b1;
  assign mb.pri_entry = {ent_reg[2], ent_reg[1], ent_reg[0] | 32'h1};
  assign mb.q_entry = {ent_reg[2], ent_reg[1], ent_reg[0] | 32'h1};

  // acknowledge write clears the valid flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= do_wr && awaddr_reg == A_ACK && wdata_reg[0];
    end
  end
  assign mb.resp_clr = clr_reg;

  // acknowledge cycle once per request, vector kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iack_reg <= 1'b0;
      iack_done_reg <= 1'b0;
      vector_reg <= '0;
    end else begin
      iack_reg <= mb.irq_req && !iack_done_reg && !iack_reg;
      if (iack_reg) begin
        vector_reg <= mb.iack_vector;
        iack_done_reg <= 1'b1;
      end else if (!mb.irq_req) begin
        iack_done_reg <= 1'b0;
      end
    end
  end
  assign mb.iack = iack_reg;

  // Read decode
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      A_ENTRY0: rd_val = ent_reg[0];
      A_ENTRY1: rd_val = ent_reg[1];
      A_ENTRY2: rd_val = ent_reg[2];
      A_STATUS: rd_val = {25'h0, 2'(next_reg), mb.irq_req,
                          mb.q_busy[next_reg], 1'b0,
                          mb.resp_status[S_VALID], mb.pri_busy};
      A_RSTAT: rd_val = mb.resp_status;
      A_RESP0: rd_val = mb.resp_entry[31:0];
      A_RESP1: rd_val = mb.resp_entry[63:32];
      A_RESP2: rd_val = mb.resp_entry[95:64];
      A_VECTOR: rd_val = {24'h0, vector_reg};
      default: begin
        rd_val = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### command_mailbox_chk.sv
// Purpose: Concurrent checks on the mailbox signals between both ends.
// Assumes: One clock domain, reset low and synchronous.
// Notes: Instantiated beside the interface, no bind.
`timescale 1ns/100ps
`default_nettype none
module command_mailbox_chk
  import cmdmb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Submission side
  input wire logic pri_set,
  input wire logic pri_busy,
  input wire logic q_set,
  input wire logic [QIDX_W-1:0] q_idx,
  input wire logic [QDEPTH-1:0] q_busy,
  // Completion side
  input wire logic resp_clr,
  input wire logic [31:0] resp_status,
  input wire logic [ENTRY_W-1:0] resp_entry,
  input wire logic irq_req,
  input wire logic iack,
  input wire logic [7:0] iack_vector
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A completion being posted
  sequence post_s;
    $rose(resp_status[S_VALID]);
  endsequence
  pri_own_a: assert property (pri_set |-> !pri_busy)
    else $error("priority slot written while owned");
  queue_own_a: assert property (q_set |-> !q_busy[q_idx])
    else $error("queue slot written while owned");
  pri_take_a: assert property (pri_set |=> pri_busy)
    else $error("priority semaphore not set");
  queue_take_a: assert property (q_set |=> q_busy[$past(q_idx)])
    else $error("queue semaphore not set");
  resp_hold_a: assert property (resp_status[S_VALID] && !resp_clr |=>
    resp_status[S_VALID] && $stable(resp_entry))
    else $error("response changed before clear");
  resp_clear_a: assert property (resp_status[S_VALID] && resp_clr |=>
    !resp_status[S_VALID])
    else $error("response valid not cleared");
  irq_post_a: assert property (post_s and resp_entry[F_IRQ_EN] |->
    irq_req)
    else $error("completion without interrupt");
  irq_gate_a: assert property ($rose(irq_req) |-> post_s)
    else $error("interrupt without new completion");
  irq_drop_a: assert property (iack && irq_req |=> !irq_req)
    else $error("request kept after acknowledge");
  irq_vector_a: assert property ($rose(irq_req) |-> iack_vector ==
    ((resp_status[S_ERROR] || resp_status[S_BADLEN]) ?
    resp_entry[F_EVEC_LSB +: 8] : resp_entry[F_NVEC_LSB +: 8]))
    else $error("wrong interrupt vector");
endmodule
`default_nettype wire

// ### command_mailbox_handshake_tb.sv
// Purpose: Bench for host and board ends joined by the mailbox.
// Assumes: Software over AXI4-Lite, execution engine modelled here.
// Notes: Every wait is a bounded loop.
`timescale 1ns/100ps
`default_nettype none
module command_mailbox_handshake_tb;
  import cmdmb_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic cmd_done = 1'b0, cmd_error = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cmd_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [ENTRY_W-1:0] cmd_entry;
  logic [7:0] cmd_cdb_len;
  int mismatches = 0, compares = 0;
  int irqs = 0;
  // Clock
  always #5 aclk = ~aclk;
  command_mailbox_if mb_if (.aclk(aclk), .aresetn(aresetn));
  // Requests are short-lived: the host acknowledges them at once
  always @(posedge mb_if.irq_req) irqs++;
  command_mailbox_host command_mailbox_host_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mb(mb_if));
  command_mailbox_device command_mailbox_device_i (.aclk(aclk),
    .aresetn(aresetn), .mb(mb_if), .cmd_valid(cmd_valid),
    .cmd_entry(cmd_entry), .cmd_cdb_len(cmd_cdb_len),
    .cmd_done(cmd_done), .cmd_error(cmd_error));
  command_mailbox_chk command_mailbox_chk_i (.aclk(aclk),
    .aresetn(aresetn), .pri_set(mb_if.pri_set), .pri_busy(mb_if.pri_busy),
    .q_set(mb_if.q_set), .q_idx(mb_if.q_idx), .q_busy(mb_if.q_busy),
    .resp_clr(mb_if.resp_clr), .resp_status(mb_if.resp_status),
    .resp_entry(mb_if.resp_entry), .irq_req(mb_if.irq_req),
    .iack(mb_if.iack), .iack_vector(mb_if.iack_vector));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // A bound ran out
  task automatic lost(input int n);
    if (n > 200) begin
      chk("wait", 32'h0, 32'h1);
      wrap_up();
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
      lost(n);
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
      lost(n);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    chk("rresp", 32'h0, {30'h0, r});
  endtask
  task automatic submit(input logic pri, input logic [31:0] w0, w1, w2);
    wr(A_ENTRY0, w0);
    wr(A_ENTRY1, w1);
    wr(A_ENTRY2, w2);
    wr(A_SUBMIT, {31'h0, pri});
  endtask
  // Wait until the engine is handed a command
  task automatic wait_run();
    int n;
    n = 0;
    @(negedge aclk);
    while (cmd_valid !== 1'b1) begin
      @(negedge aclk);
      n++;
      lost(n);
    end
  endtask
  // Engine finishes, software reads the response and clears it
  task automatic finish(input logic err, input logic [7:0] vec);
    logic [31:0] d;
    int n;
    int k;
    n = 0;
    d = 32'h0;
    k = irqs;
    @(posedge aclk);
    cmd_done <= 1'b1;
    cmd_error <= err;
    @(posedge aclk);
    cmd_done <= 1'b0;
    cmd_error <= 1'b0;
    while (d[1] !== 1'b1) begin
      rd(A_STATUS, d);
      n++;
      lost(n * 10);
    end
    chk("irq", 32'h1, 32'(irqs - k)); // one interrupt
    rd(A_RSTAT, d);
    chk("valid", 32'h1, {31'h0, d[S_VALID]}); // valid bit
    chk("error", {31'h0, err}, {31'h0, d[S_ERROR]}); // status
    rd(A_VECTOR, d);
    chk("vector", {24'h0, vec}, {24'h0, d[7:0]}); // cause vector
    wr(A_ACK, 32'h1);
    rd(A_STATUS, d);
    chk("cleared", 32'h0, {31'h0, d[1]}); // flag cleared
  endtask
  task automatic t_groups();
    logic [7:0] lens [8] = '{8'h06, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'h0c,
                             8'h08, 8'h10};
    int g;
    for (g = 0; g < 8; g++) begin
      submit(1'b1, {(g == 6) ? 16'h0014 : (g == 7) ? 16'h0018 : 16'h0055,
             16'h0005}, 32'h100, {8'ha5, 8'h5a, 8'h20, 3'(g), 5'h00});
      wait_run();
      chk("cdb_len", {24'h0, lens[g]}, {24'h0, cmd_cdb_len});
      chk("group", {29'h0, 3'(g)}, {29'h0, cmd_entry[71:69]});
      finish(g == 5, (g > 2 && g < 6) ? 8'h5a : 8'ha5);
    end
  endtask
  task automatic t_order();
    submit(1'b0, 32'h0000_0105, 32'h11, 32'ha55a_2000);
    wait_run();
    chk("first", 32'h11, cmd_entry[63:32]); // queue intake
    submit(1'b0, 32'h0000_0105, 32'h22, 32'ha55a_2000);
    submit(1'b0, 32'h0000_0107, 32'h44, 32'ha55a_2000);
    submit(1'b1, 32'h0000_0005, 32'h33, 32'ha55a_2000);
    finish(1'b0, 8'ha5);
    wait_run();
    chk("priority", 32'h33, cmd_entry[63:32]); // precedence
    finish(1'b0, 8'ha5);
    wait_run();
    chk("high", 32'h44, cmd_entry[63:32]); // high priority
    finish(1'b0, 8'ha5);
    wait_run();
    chk("queued", 32'h22, cmd_entry[63:32]); // order kept
    finish(1'b0, 8'ha5);
  endtask
  task automatic t_bad();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h30, d, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(A_STATUS, 32'h0, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_bad();
    $display("test bad address done");
    t_groups();
    $display("test group decode done");
    t_order();
    $display("test ordering done");
    wrap_up();
  end
endmodule
`default_nettype wire
